// File: logic/cssl_pkg.sv
// Shared constants and types for the stack and status logic.
package cssl_pkg;

	// Register port word offsets.
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CORE_CTRL = 4'h1;
	localparam logic [3:0] REG_INT_CTRL1 = 4'h2;
	localparam logic [3:0] REG_STACK_PTR = 4'h3;

	// Stack pointer reset value, step per word and alignment mask.
	localparam logic [15:0] SP_RESET = 16'h1000;
	localparam logic [15:0] STACK_STEP = 16'h0002;
	localparam logic [15:0] SP_ALIGN_MASK = 16'hFFFE;

	// Status register layout and software access masks.
	localparam logic [15:0] SR_RESET = 16'h0000;
	localparam logic [15:0] SR_SW_MASK = 16'hF10F;
	localparam logic [15:0] SR_CLR_MASK = 16'h0C00;
	localparam int SR_IPL_LO = 5;
	localparam int SR_IPL_HI = 7;
	localparam logic [2:0] IPL_ALL_OFF = 3'h7;

	// Control register bit positions.
	localparam int CORE_IPL3_BIT = 3;
	localparam int CORE_FRAME_BIT = 2;
	localparam int INT_NEST_BIT = 15;

	// Stacked word layout.
	localparam int PC_HI_LSB = 16;
	localparam int SRL_LSB = 8;
	localparam logic [15:0] PC_HI_MASK = 16'h007F;
	localparam logic [15:0] SRL_MASK = 16'h00FF;

	// Operand masks: near data space, short and long literals.
	localparam logic [15:0] NEAR_MASK = 16'h1FFF;
	localparam logic [15:0] LIT5_MASK = 16'h001F;
	localparam logic [15:0] LIT10_MASK = 16'h03FF;

	// Working register indices with special roles.
	localparam logic [3:0] W0_IDX = 4'h0;
	localparam logic [3:0] FP_IDX = 4'hE;
	localparam logic [3:0] SP_IDX = 4'hF;

	// Commands from the execution logic.
	typedef enum logic [2:0] {CMD_CALL, CMD_EXC, CMD_RET, CMD_RETFIE,
		CMD_WRITE_W, CMD_READ_W, CMD_EADDR} cssl_cmd_t;

	// Operand addressing modes.
	typedef enum logic [2:0] {MODE_DIRECT, MODE_INDIRECT, MODE_POST, MODE_PRE,
		MODE_LIT5, MODE_LIT10, MODE_FILE, MODE_MOVE} cssl_mode_t;

	// Sequencer states.
	typedef enum logic [2:0] {ST_IDLE, ST_PUSH_HI, ST_POP_LO, ST_POP_HIDATA,
		ST_POP_LODATA, ST_W_USE} cssl_state_t;

endpackage

// File: logic/cssl_default_working_reg_mem.sv
`timescale 1ns/100ps
// Working register storage; the read word is registered.
module cssl_default_working_reg_mem (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wrEn,
	input wire logic [3:0] wrIdx,
	input wire logic [15:0] wrData,
	input wire logic [3:0] rdIdx,
	output logic [15:0] rdData
);

	// All state of the store.
	typedef struct packed {
		logic [15:0][15:0] words;
		logic [15:0] rd;
	} cssl_mem_t;

	cssl_mem_t mem_q;
	cssl_mem_t mem_d;

	// Read sees the old word when it hits a word written in the same cycle.
	always_comb begin
		mem_d = mem_q;
		mem_d.rd = mem_q.words[rdIdx];
		if (wrEn) begin
			mem_d.words[wrIdx] = wrData;
		end
	end

	// Registers clear on reset.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_q <= '0;
		end else begin
			mem_q <= mem_d;
		end
	end

	assign rdData = mem_q.rd;

endmodule // cssl_default_working_reg_mem

// File: logic/cssl_core.sv
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// - Stack pointer bit zero always reads zero.
// - Every reset loads stack pointer with 0x1000.
// - Pointer at next free word; grows upward.
// - Push counter low word, then high bits.
// - Call push zero-fills upper second word.
// - Exception push carries status low byte.
// - Stack pointer never paged; frame pointer unpaged only in frame mode.
// - Stack pointer accessible like any working register.
// - File address is 13 bits, near space.
// - File operations default to working register zero.
// - Move reaches the whole data space.
// - Three-operand: direct register, register or literal.
// - Direct, indirect, post, pre, literal modes.
// - Status bits 7-5 hold priority; 7 masks.
// - Top priority bit from core control.
// - Priority bits locked against port writes while nesting disabled.
module cssl_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdData,
	input wire logic cmdValid,
	input cssl_pkg::cssl_cmd_t cmdCode,
	input cssl_pkg::cssl_mode_t cmdMode,
	input wire logic [3:0] cmdReg,
	input wire logic [15:0] cmdData,
	input wire logic cmdDec,
	input wire logic [22:0] cmdPc,
	input wire logic [2:0] cmdLevel,
	output logic cmdReady,
	output logic opDone,
	output logic [15:0] opResult,
	output logic [15:0] opAddr,
	output logic [22:0] opPc,
	output logic opNoPage,
	output logic memWe,
	output logic memRe,
	output logic [15:0] memAddr,
	output logic [15:0] memWrData,
	input wire logic [15:0] memRdData,
	output logic [3:0] cpuPriority,
	output logic userIntOff
);

	// All state of the block but the working register store in one record.
	typedef struct packed {
		cssl_pkg::cssl_state_t state;
		cssl_pkg::cssl_cmd_t code;
		cssl_pkg::cssl_mode_t mode;
		logic [3:0] reg_;
		logic [15:0] data;
		logic dec;
		logic [15:0] sp;
		logic [15:0] sr;
		logic ipl3;
		logic frameMode;
		logic nestDis;
		logic [15:0] hiWord;
		logic [15:0] rdData;
		logic ready;
		logic done;
		logic [15:0] result;
		logic [15:0] addr;
		logic [22:0] pc;
		logic noPage;
		logic memWe;
		logic memRe;
		logic [15:0] memAddr;
		logic [15:0] memWrData;
		logic [3:0] prio;
		logic intOff;
	} cssl_core_t;

	cssl_core_t st_q;
	cssl_core_t st_d;

	// Working register store ports, driven by the next-state logic.
	logic wrfWe;
	logic [3:0] wrfWrIdx;
	logic [15:0] wrfWrData;
	logic [3:0] wrfRdIdx;
	logic [15:0] wrfRdData;

	// Helpers for the sequencer and the checks below.
	logic accept;
	logic [15:0] wVal;
	logic [15:0] wMod;
	logic [15:0] spLess;
	logic [15:0] pcHiWord;

	cssl_default_working_reg_mem u_default_working_reg (
		.clk(clk),
		.rst_n(rst_n),
		.wrEn(wrfWe),
		.wrIdx(wrfWrIdx),
		.wrData(wrfWrData),
		.rdIdx(wrfRdIdx),
		.rdData(wrfRdData)
	);

	// A command is taken only while the sequencer is idle.
	assign accept = cmdValid && st_q.ready;
	// The stack pointer lives in flops, the rest in the store.
	assign wVal = (st_q.reg_ == cssl_pkg::SP_IDX) ? st_q.sp : wrfRdData;
	// Modified pointer for the post and pre modes, one word either way.
	assign wMod = st_q.dec ? (wVal - cssl_pkg::STACK_STEP) : (wVal + cssl_pkg::STACK_STEP);
	assign spLess = st_q.sp - cssl_pkg::STACK_STEP;
	// Upper counter bits land in the low seven bits, the rest zero.
	assign pcHiWord = 16'(cmdPc >> cssl_pkg::PC_HI_LSB);

	// Next-state logic: register port first, the sequencer after it.
	// The sequencer wins on the stack pointer, so a port write in a
	// push or pop cycle is lost; software must not race the hardware.
	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		st_d.memWe = 1'b0;
		st_d.memRe = 1'b0;
		wrfWe = 1'b0;
		wrfWrIdx = st_q.reg_;
		wrfWrData = cmdData;
		wrfRdIdx = cmdReg;

		// Register port writes.
		if (regWr) begin
			case (regAddr)
				cssl_pkg::REG_STATUS: begin
					st_d.sr = (st_q.sr & ~cssl_pkg::SR_SW_MASK) |
						(regWrData & cssl_pkg::SR_SW_MASK);
					// Sticky overflow bits can only be cleared.
					st_d.sr = st_d.sr & (~cssl_pkg::SR_CLR_MASK | regWrData);
					// The priority field is frozen while nesting is off.
					if (!st_q.nestDis) begin
						st_d.sr[cssl_pkg::SR_IPL_HI:cssl_pkg::SR_IPL_LO] =
							regWrData[cssl_pkg::SR_IPL_HI:cssl_pkg::SR_IPL_LO];
					end
				end
				cssl_pkg::REG_CORE_CTRL: begin
					st_d.ipl3 = regWrData[cssl_pkg::CORE_IPL3_BIT];
					st_d.frameMode = regWrData[cssl_pkg::CORE_FRAME_BIT];
				end
				cssl_pkg::REG_INT_CTRL1: begin
					st_d.nestDis = regWrData[cssl_pkg::INT_NEST_BIT];
				end
				cssl_pkg::REG_STACK_PTR: begin
					st_d.sp = regWrData & cssl_pkg::SP_ALIGN_MASK;
				end
				default: begin
					// Unmapped offsets ignore writes.
				end
			endcase
		end

		// Register port reads; data stand from the next cycle until the next read.
		if (regRd) begin
			case (regAddr)
				cssl_pkg::REG_STATUS: st_d.rdData = st_q.sr;
				cssl_pkg::REG_CORE_CTRL: st_d.rdData =
					(16'(st_q.ipl3) << cssl_pkg::CORE_IPL3_BIT) |
					(16'(st_q.frameMode) << cssl_pkg::CORE_FRAME_BIT);
				cssl_pkg::REG_INT_CTRL1: st_d.rdData =
					16'(st_q.nestDis) << cssl_pkg::INT_NEST_BIT;
				cssl_pkg::REG_STACK_PTR: st_d.rdData = st_q.sp;
				default: st_d.rdData = '0;
			endcase
		end

		// Command sequencer.
		case (st_q.state)
			cssl_pkg::ST_IDLE: begin
				if (accept) begin
					st_d.code = cmdCode;
					st_d.mode = cmdMode;
					st_d.reg_ = cmdReg;
					st_d.data = cmdData;
					st_d.dec = cmdDec;
					case (cmdCode)
						cssl_pkg::CMD_CALL, cssl_pkg::CMD_EXC: begin
							// Low counter word first, at the free word.
							st_d.memWe = 1'b1;
							st_d.memAddr = st_q.sp;
							st_d.memWrData = cmdPc[15:0];
							st_d.sp = st_q.sp + cssl_pkg::STACK_STEP;
							st_d.hiWord = pcHiWord;
							if (cmdCode == cssl_pkg::CMD_EXC) begin
								// Old status low byte rides with the counter.
								st_d.hiWord = pcHiWord |
									((st_q.sr & cssl_pkg::SRL_MASK) << cssl_pkg::SRL_LSB);
								st_d.sr[cssl_pkg::SR_IPL_HI:cssl_pkg::SR_IPL_LO] = cmdLevel;
							end
							st_d.state = cssl_pkg::ST_PUSH_HI;
						end
						cssl_pkg::CMD_RET, cssl_pkg::CMD_RETFIE: begin
							// Decrement before the read; high word comes back first.
							st_d.memRe = 1'b1;
							st_d.memAddr = spLess;
							st_d.sp = spLess;
							st_d.state = cssl_pkg::ST_POP_LO;
						end
						cssl_pkg::CMD_WRITE_W: begin
							if (cmdReg == cssl_pkg::SP_IDX) begin
								st_d.sp = cmdData & cssl_pkg::SP_ALIGN_MASK;
							end else begin
								wrfWe = 1'b1;
								wrfWrIdx = cmdReg;
							end
							st_d.done = 1'b1;
						end
						default: begin
							// Reads and address work need the stored word first.
							if (cmdCode == cssl_pkg::CMD_EADDR && cmdMode == cssl_pkg::MODE_FILE) begin
								wrfRdIdx = cssl_pkg::W0_IDX;
								st_d.reg_ = cssl_pkg::W0_IDX;
							end
							st_d.state = cssl_pkg::ST_W_USE;
						end
					endcase
				end
			end
			cssl_pkg::ST_PUSH_HI: begin
				// Second word at the next free location.
				st_d.memWe = 1'b1;
				st_d.memAddr = st_q.sp;
				st_d.memWrData = st_q.hiWord;
				st_d.sp = st_q.sp + cssl_pkg::STACK_STEP;
				st_d.done = 1'b1;
				st_d.state = cssl_pkg::ST_IDLE;
			end
			cssl_pkg::ST_POP_LO: begin
				st_d.memRe = 1'b1;
				st_d.memAddr = spLess;
				st_d.sp = spLess;
				st_d.state = cssl_pkg::ST_POP_HIDATA;
			end
			cssl_pkg::ST_POP_HIDATA: begin
				st_d.hiWord = memRdData;
				st_d.state = cssl_pkg::ST_POP_LODATA;
			end
			cssl_pkg::ST_POP_LODATA: begin
				st_d.pc = (23'(st_q.hiWord & cssl_pkg::PC_HI_MASK) << cssl_pkg::PC_HI_LSB) |
					23'(memRdData);
				if (st_q.code == cssl_pkg::CMD_RETFIE) begin
					// Restore the status low byte saved on entry.
					st_d.sr = (st_q.sr & ~cssl_pkg::SRL_MASK) |
						((st_q.hiWord >> cssl_pkg::SRL_LSB) & cssl_pkg::SRL_MASK);
				end
				st_d.done = 1'b1;
				st_d.state = cssl_pkg::ST_IDLE;
			end
			cssl_pkg::ST_W_USE: begin
				st_d.result = wVal;
				st_d.addr = '0;
				// The stack pointer, and the frame pointer in frame mode, stay unpaged.
				st_d.noPage = (st_q.reg_ == cssl_pkg::SP_IDX) ||
					(st_q.reg_ == cssl_pkg::FP_IDX && st_q.frameMode);
				if (st_q.code == cssl_pkg::CMD_EADDR) begin
					case (st_q.mode)
						cssl_pkg::MODE_DIRECT: st_d.result = wVal;
						cssl_pkg::MODE_INDIRECT: st_d.addr = wVal;
						cssl_pkg::MODE_POST: begin
							st_d.addr = wVal;
							wrfWe = (st_q.reg_ != cssl_pkg::SP_IDX);
							wrfWrData = wMod;
							if (st_q.reg_ == cssl_pkg::SP_IDX) begin
								st_d.sp = wMod & cssl_pkg::SP_ALIGN_MASK;
							end
						end
						cssl_pkg::MODE_PRE: begin
							st_d.addr = wMod;
							wrfWe = (st_q.reg_ != cssl_pkg::SP_IDX);
							wrfWrData = wMod;
							if (st_q.reg_ == cssl_pkg::SP_IDX) begin
								st_d.sp = wMod & cssl_pkg::SP_ALIGN_MASK;
							end
						end
						cssl_pkg::MODE_LIT5: st_d.result = st_q.data & cssl_pkg::LIT5_MASK;
						cssl_pkg::MODE_LIT10: st_d.result = st_q.data & cssl_pkg::LIT10_MASK;
						cssl_pkg::MODE_FILE: begin
							// Near space only; the operand is the default register.
							st_d.addr = st_q.data & cssl_pkg::NEAR_MASK;
							st_d.noPage = 1'b0;
						end
						cssl_pkg::MODE_MOVE: st_d.addr = st_q.data;
						default: st_d.addr = '0;
					endcase
				end
				st_d.done = 1'b1;
				st_d.state = cssl_pkg::ST_IDLE;
			end
			default: st_d.state = cssl_pkg::ST_IDLE;
		endcase

		// Registered ready flag and views of the effective priority.
		st_d.ready = (st_d.state == cssl_pkg::ST_IDLE);
		st_d.prio = {st_d.ipl3, st_d.sr[cssl_pkg::SR_IPL_HI:cssl_pkg::SR_IPL_LO]};
		st_d.intOff = st_d.ipl3 ||
			(st_d.sr[cssl_pkg::SR_IPL_HI:cssl_pkg::SR_IPL_LO] == cssl_pkg::IPL_ALL_OFF);
	end

	// State register; every reset reloads the stack pointer.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.state <= cssl_pkg::ST_IDLE;
			st_q.sp <= cssl_pkg::SP_RESET;
			st_q.sr <= cssl_pkg::SR_RESET;
			st_q.ready <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state flops.
	assign regRdData = st_q.rdData;
	assign cmdReady = st_q.ready;
	assign opDone = st_q.done;
	assign opResult = st_q.result;
	assign opAddr = st_q.addr;
	assign opPc = st_q.pc;
	assign opNoPage = st_q.noPage;
	assign memWe = st_q.memWe;
	assign memRe = st_q.memRe;
	assign memAddr = st_q.memAddr;
	assign memWrData = st_q.memWrData;
	assign cpuPriority = st_q.prio;
	assign userIntOff = st_q.intOff;

	// Checks.
	logic [15:0] pcLo;
	logic [7:0] srLow;
	logic [2:0] iplNow;
	assign pcLo = cmdPc[15:0];
	assign srLow = st_q.sr[7:0];
	assign iplNow = st_q.sr[cssl_pkg::SR_IPL_HI:cssl_pkg::SR_IPL_LO];

	spAlign_a: assert property (@(posedge clk) disable iff (!rst_n) !st_q.sp[0])
		else $error("Stack pointer is odd.");
	spReset_a: assert property (@(posedge clk) !rst_n |=> st_q.sp == cssl_pkg::SP_RESET)
		else $error("Stack pointer not reloaded by reset.");
	pushLow_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && cmdCode == cssl_pkg::CMD_CALL |=>
		memWe && memAddr == $past(st_q.sp) && memWrData == $past(pcLo))
		else $error("Low counter word not pushed at free word.");
	callHigh_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && cmdCode == cssl_pkg::CMD_CALL |=> ##1
		memWe && memWrData[15:7] == '0 && memAddr == $past(st_q.sp, 2) + cssl_pkg::STACK_STEP)
		else $error("Call high word wrong.");
	excStatus_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && cmdCode == cssl_pkg::CMD_EXC |=> ##1 memWe && memWrData[15:8] == $past(srLow, 2))
		else $error("Status low byte not stacked.");
	popDec_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && cmdCode == cssl_pkg::CMD_RET |=>
		memRe && memAddr == $past(st_q.sp) - cssl_pkg::STACK_STEP)
		else $error("Pop did not pre-decrement.");
	pushStep_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && cmdCode == cssl_pkg::CMD_CALL |-> ##2 opDone && st_q.sp == $past(st_q.sp, 2) + 16'h0004)
		else $error("Counter push did not advance by four.");
	iplLock_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.nestDis && regWr && regAddr == cssl_pkg::REG_STATUS &&
		!(accept && cmdCode == cssl_pkg::CMD_EXC) && st_q.state != cssl_pkg::ST_POP_LODATA
		|=> $stable(iplNow))
		else $error("Priority changed while locked.");
	prioOut_a: assert property (@(posedge clk) disable iff (!rst_n)
		cpuPriority == {st_q.ipl3, iplNow})
		else $error("Effective priority wrong.");
	intOff_a: assert property (@(posedge clk) disable iff (!rst_n)
		userIntOff == (st_q.ipl3 || iplNow == cssl_pkg::IPL_ALL_OFF))
		else $error("User interrupt disable wrong.");
	nearAddr_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && cmdCode == cssl_pkg::CMD_EADDR && cmdMode == cssl_pkg::MODE_FILE |-> ##2
		opDone && opAddr == ($past(cmdData, 2) & cssl_pkg::NEAR_MASK))
		else $error("File address not near.");

endmodule // cssl_core

// File: verification/cssl_stack_mem.sv
`timescale 1ns/100ps
// Behavioural data memory that holds the software stack.
module cssl_stack_mem (
	input wire logic clk,
	input wire logic memWe,
	input wire logic memRe,
	input wire logic [15:0] memAddr,
	input wire logic [15:0] memWrData,
	output logic [15:0] memRdData
);
	// Word storage; byte address bit 0 selects nothing.
	logic [15:0] mem [0:255];
	initial memRdData = 16'h0000;
	// Read data stands one cycle only; after that the bus inverts every cycle, so stale data matches only every second cycle.
	always @(posedge clk) begin
		if (memWe) begin
			mem[memAddr[8:1]] <= memWrData;
		end
		if (memRe) begin
			memRdData <= mem[memAddr[8:1]];
		end else begin
			memRdData <= ~memRdData;
		end
	end
endmodule // cssl_stack_mem

// File: verification/test_cpu_stack_and_status_logic.sv
`timescale 1ns/100ps
// Self-checking bench for the stack and status logic.
module test_cpu_stack_and_status_logic;
	// One register row: offset, write value, read back, expected priority.
	typedef struct packed {logic [3:0] a; logic [15:0] w; logic [15:0] r; logic [3:0] p;} cssl_row_t;
	// One operand row: mode, register, data, step sign, address, result, no-page, check mask.
	typedef struct packed {cssl_pkg::cssl_mode_t m; logic [3:0] g; logic [15:0] d; logic dc;
		logic [15:0] adr; logic [15:0] res; logic np; logic [1:0] k;} cssl_ea_t;
	localparam cssl_row_t ROWS [0:11] = '{'{4'h3, 16'h2345, 16'h2344, 4'h0},
		'{4'h3, 16'hFFFF, 16'hFFFE, 4'h0}, '{4'h0, 16'h00E0, 16'h00E0, 4'h7},
		'{4'h0, 16'h0060, 16'h0060, 4'h3}, '{4'h1, 16'h0008, 16'h0008, 4'hB},
		'{4'h1, 16'h0000, 16'h0000, 4'h3}, '{4'h2, 16'h8000, 16'h8000, 4'h3},
		'{4'h0, 16'h00A0, 16'h0060, 4'h3}, '{4'h2, 16'h0000, 16'h0000, 4'h3},
		'{4'h0, 16'h0053, 16'h0043, 4'h2}, '{4'h5, 16'h1234, 16'h0000, 4'h2},
		'{4'h3, 16'h1000, 16'h1000, 4'h2}};
	localparam cssl_ea_t EAS [0:7] = '{
		'{cssl_pkg::MODE_FILE, 4'h0, 16'hFFFF, 1'b0, 16'h1FFF, 16'hBEEF, 1'b0, 2'h3},
		'{cssl_pkg::MODE_MOVE, 4'h0, 16'hFFFF, 1'b0, 16'hFFFF, 16'h0000, 1'b0, 2'h2},
		'{cssl_pkg::MODE_LIT5, 4'h0, 16'hFFFF, 1'b0, 16'h0000, 16'h001F, 1'b0, 2'h1},
		'{cssl_pkg::MODE_LIT10, 4'h0, 16'hFFFF, 1'b0, 16'h0000, 16'h03FF, 1'b0, 2'h1},
		'{cssl_pkg::MODE_DIRECT, 4'h0, 16'h0000, 1'b0, 16'h0000, 16'hBEEF, 1'b0, 2'h1},
		'{cssl_pkg::MODE_INDIRECT, 4'hE, 16'h0000, 1'b0, 16'h2000, 16'h0000, 1'b1, 2'h2},
		'{cssl_pkg::MODE_PRE, 4'hE, 16'h0000, 1'b1, 16'h1FFE, 16'h0000, 1'b1, 2'h2},
		'{cssl_pkg::MODE_POST, 4'hF, 16'h0000, 1'b0, 16'h1000, 16'h0000, 1'b1, 2'h2}};
	logic clk = 1'b0;
	logic rst_n, regWr, regRd, cmdValid, cmdDec, cmdReady, opDone, opNoPage, memWe, memRe;
	logic userIntOff;
	logic [3:0] regAddr, cmdReg, cpuPriority;
	logic [15:0] regWrData, regRdData, cmdData, opResult, opAddr, memAddr, memWrData;
	logic [15:0] memRdData, rd;
	logic [22:0] cmdPc, opPc;
	logic [2:0] cmdLevel;
	cssl_pkg::cssl_cmd_t cmdCode;
	cssl_pkg::cssl_mode_t cmdMode;
	int fails = 0;
	int checked = 0;

	cssl_core i_cssl_core (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cmdValid(cmdValid),
		.cmdCode(cmdCode), .cmdMode(cmdMode), .cmdReg(cmdReg), .cmdData(cmdData),
		.cmdDec(cmdDec), .cmdPc(cmdPc), .cmdLevel(cmdLevel), .cmdReady(cmdReady),
		.opDone(opDone), .opResult(opResult), .opAddr(opAddr), .opPc(opPc),
		.opNoPage(opNoPage), .memWe(memWe), .memRe(memRe), .memAddr(memAddr),
		.memWrData(memWrData), .memRdData(memRdData), .cpuPriority(cpuPriority),
		.userIntOff(userIntOff));
	cssl_stack_mem i_cssl_stack_mem (.clk(clk), .memWe(memWe), .memRe(memRe),
		.memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData));

	// Free-running 125 MHz clock.
	always #4 clk = ~clk;

	// Word comparison for register, memory and operand values.
	task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask

	// Counter comparison for popped return addresses.
	task automatic chkPc(input logic [22:0] got, input logic [22:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: counter %h, expected %h", $time, got, exp);
		end
	endtask

	// Small comparison for priority and single flags.
	task automatic chkFlag(input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: flag %h, expected %h", $time, got, exp);
		end
	endtask

	// One-cycle register write.
	task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// One-cycle register read; data is taken in the following cycle only.
	task automatic regRead(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		d = regRdData;
	endtask

	// Issue one command and wait, bounded, for its completion pulse.
	task automatic cmd(input cssl_pkg::cssl_cmd_t c, input cssl_pkg::cssl_mode_t m,
		input logic [3:0] g, input logic [15:0] d, input logic dc, input logic [22:0] pc,
		input logic [2:0] lv);
		int n;
		n = 0;
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdCode <= c;
		cmdMode <= m;
		cmdReg <= g;
		cmdData <= d;
		cmdDec <= dc;
		cmdPc <= pc;
		cmdLevel <= lv;
		@(posedge clk);
		cmdValid <= 1'b0;
		// A register write finishes in the accept cycle, so look before the next edge.
		#1;
		while (opDone !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		chkFlag({3'h0, opDone}, 4'h1);
		// The port must be free again in the cycle of the completion pulse.
		chkFlag({3'h0, cmdReady}, 4'h1);
	endtask

	// Single place where the run ends.
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under a thousand cycles.
	initial begin
		#40000;
		fails++;
		end_of_test();
	end

	// Main sequence.
	initial begin
		rst_n <= 1'b0;
		regWr <= 1'b0;
		regRd <= 1'b0;
		regAddr <= 4'h0;
		regWrData <= 16'h0000;
		cmdValid <= 1'b0;
		cmdCode <= cssl_pkg::CMD_WRITE_W;
		cmdMode <= cssl_pkg::MODE_DIRECT;
		cmdReg <= 4'h0;
		cmdData <= 16'h0000;
		cmdDec <= 1'b0;
		cmdPc <= 23'h000000;
		cmdLevel <= 3'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		regRead(cssl_pkg::REG_STACK_PTR, rd);
		chkWord(rd, 16'h1000);
		$display("Test reset values done");
		// Register rows: write, read back, then check the derived priority outputs.
		foreach (ROWS[i]) begin
			regWrite(ROWS[i].a, ROWS[i].w);
			regRead(ROWS[i].a, rd);
			chkWord(rd, ROWS[i].r);
			chkFlag(cpuPriority, ROWS[i].p);
			chkFlag({3'h0, userIntOff}, {3'h0, ROWS[i].p[3] | (&ROWS[i].p[2:0])});
		end
		$display("Test register rows done");
		// Call push: low word, then zero-filled high bits, pointer up by four.
		cmd(cssl_pkg::CMD_CALL, cssl_pkg::MODE_DIRECT, 4'h0, 16'h0000, 1'b0, 23'h5A1234, 3'h0);
		// The second word lands one edge after the completion pulse; the read gives it time.
		regRead(cssl_pkg::REG_STACK_PTR, rd);
		chkWord(rd, 16'h1004);
		chkWord(i_cssl_stack_mem.mem[0], 16'h1234);
		chkWord(i_cssl_stack_mem.mem[1], 16'h005A);
		cmd(cssl_pkg::CMD_READ_W, cssl_pkg::MODE_DIRECT, 4'hF, 16'h0000, 1'b0, 23'h0, 3'h0);
		chkWord(opResult, 16'h1004);
		// Exception push carries the old status low byte beside the high counter bits.
		cmd(cssl_pkg::CMD_EXC, cssl_pkg::MODE_DIRECT, 4'h0, 16'h0000, 1'b0, 23'h3F0ABC, 3'h5);
		regRead(cssl_pkg::REG_STATUS, rd);
		chkWord(rd, 16'h00A3);
		chkWord(i_cssl_stack_mem.mem[2], 16'h0ABC);
		chkWord(i_cssl_stack_mem.mem[3], 16'h433F);
		chkFlag(cpuPriority, 4'h5);
		// Pops come back in reverse order; the interrupt return restores the status low byte.
		cmd(cssl_pkg::CMD_RETFIE, cssl_pkg::MODE_DIRECT, 4'h0, 16'h0000, 1'b0, 23'h0, 3'h0);
		chkPc(opPc, 23'h3F0ABC);
		regRead(cssl_pkg::REG_STATUS, rd);
		chkWord(rd, 16'h0043);
		cmd(cssl_pkg::CMD_RET, cssl_pkg::MODE_DIRECT, 4'h0, 16'h0000, 1'b0, 23'h0, 3'h0);
		chkPc(opPc, 23'h5A1234);
		regRead(cssl_pkg::REG_STACK_PTR, rd);
		chkWord(rd, 16'h1000);
		$display("Test stack push and pop done");
		// Operand rows with a known default register and frame pointer mode on.
		cmd(cssl_pkg::CMD_WRITE_W, cssl_pkg::MODE_DIRECT, 4'h0, 16'hBEEF, 1'b0, 23'h0, 3'h0);
		cmd(cssl_pkg::CMD_WRITE_W, cssl_pkg::MODE_DIRECT, 4'hE, 16'h2000, 1'b0, 23'h0, 3'h0);
		regWrite(cssl_pkg::REG_CORE_CTRL, 16'h0004);
		foreach (EAS[i]) begin
			cmd(cssl_pkg::CMD_EADDR, EAS[i].m, EAS[i].g, EAS[i].d, EAS[i].dc, 23'h0, 3'h0);
			if (EAS[i].k[1]) begin
				chkWord(opAddr, EAS[i].adr);
				chkFlag({3'h0, opNoPage}, {3'h0, EAS[i].np});
			end
			if (EAS[i].k[0]) begin
				chkWord(opResult, EAS[i].res);
			end
		end
		regRead(cssl_pkg::REG_STACK_PTR, rd);
		chkWord(rd, 16'h1002);
		// The pre-modified frame pointer must have been written back.
		cmd(cssl_pkg::CMD_READ_W, cssl_pkg::MODE_DIRECT, 4'hE, 16'h0000, 1'b0, 23'h0, 3'h0);
		chkWord(opResult, 16'h1FFE);
		$display("Test operand modes done");
		// A reset in mid-run must reload the pointer whatever software left there.
		regWrite(cssl_pkg::REG_STACK_PTR, 16'h3000);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		regRead(cssl_pkg::REG_STACK_PTR, rd);
		chkWord(rd, 16'h1000);
		chkFlag(cpuPriority, 4'h0);
		$display("Test second reset done");
		end_of_test();
	end
endmodule // test_cpu_stack_and_status_logic
